// File: verilog/lcr_regs.sv
// Lane conditioning register slice: holds emphasis, idle/rate, equaliser,
// swing and idle threshold settings and drives them to the analog side.
// Assumes the management engine presents byte reads/writes on core_clk_i
// and that the detector inputs come from the analog, asynchronous domain.
`timescale 1ns/1ps
`default_nettype none
module lcr_regs
   import lcr_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   output logic             reg_ack_o,
   input  wire logic        input_lane1_idle_raw_i,
   input  wire logic        input_lane1_rate_high_raw_i,
   output logic             output_b_lane0_tx_emphasis_type_o,
   output logic      [6:0]  output_b_lane0_tx_emphasis_level_o,
   output logic             output_a_lane1_tx_emphasis_type_o,
   output logic      [6:0]  output_a_lane1_tx_emphasis_level_o,
   output logic             output_a_lane1_mute_o,
   output logic             output_a_lane1_signal_detect_en_o,
   output logic             output_a_lane1_rate_high_o,
   output logic      [6:0]  output_a_lane1_output_swing_o,
   output logic             output_a_lane1_swing_reserved_o,
   output logic             input_lane1_eq_enable_o,
   output logic      [1:0]  input_lane1_gain_stage_o,
   output logic      [2:0]  input_lane1_boost_level_o,
   output lcr_thresh_t      input_lane1_thresh_deassert_o,
   output lcr_thresh_t      input_lane1_thresh_assert_o
);
   // =========================================================
   // Storage
   logic [7:0] b0_emph;
   logic [7:0] a1_idle_rate;
   logic [7:0] in1_eq;
   logic [7:0] a1_swing;
   logic [7:0] a1_emph;
   logic [7:0] in1_thresh;
   logic [7:0] next_b0_emph;
   logic [7:0] next_a1_idle_rate;
   logic [7:0] next_in1_eq;
   logic [7:0] next_a1_swing;
   logic [7:0] next_a1_emph;
   logic [7:0] next_in1_thresh;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic       ack;
   logic       next_ack;
   logic       hit;
   logic [7:0] wmasked;

   // =========================================================
   // Detector synchronisers
   logic [1:0] sync_meta;
   logic [1:0] sync_mid;
   logic [1:0] sync_late;
   logic [1:0] seen;
   logic [1:0] next_seen;
   logic [1:0] raw_in;

   lcr_ctrl_if cif ();

   // The agree filter below is written for exactly three stages
   if (SYNC_STAGES != 3)
   begin : g_sync_depth
      $error("synchroniser depth must be three");
   end

   assign raw_in = {input_lane1_rate_high_raw_i, input_lane1_idle_raw_i};

   // A level is taken only once the last two stages agree,
   // which filters a single-cycle metastable settle
   always_comb
   begin
      next_seen = seen;
      for (int i = 0; i < 2; i++)
      begin
         if (sync_mid[i] == sync_late[i])
            next_seen[i] = sync_late[i];
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         sync_meta <= 2'h0;
         sync_mid  <= 2'h0;
         sync_late <= 2'h0;
         seen      <= 2'h0;
      end
      else
      begin
         sync_meta <= raw_in;
         sync_mid  <= sync_meta;
         sync_late <= sync_mid;
         seen      <= next_seen;
      end
   end

   // =========================================================
   // Address decode and write
   always_comb
   begin
      unique case (reg_addr_i)
         OFS_B0_EMPH,
         OFS_A1_IDLE_RATE,
         OFS_IN1_EQ,
         OFS_A1_SWING,
         OFS_A1_EMPH,
         OFS_IN1_THRESH: hit = 1'b1;
         default:        hit = 1'b0;
      endcase
   end

   assign wmasked = reg_wdata_i;

   // Reserved bits are masked off so a careless host cannot
   // push reserved bit positions into the analog trims
   always_comb
   begin
      next_b0_emph      = b0_emph;
      next_a1_idle_rate = a1_idle_rate;
      next_in1_eq       = in1_eq;
      next_a1_swing     = a1_swing;
      next_a1_emph      = a1_emph;
      next_in1_thresh   = in1_thresh;
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            OFS_B0_EMPH:      next_b0_emph = wmasked & MSK_EMPH;
            OFS_A1_IDLE_RATE: next_a1_idle_rate =
                                 wmasked & MSK_IDLE_RATE;
            OFS_IN1_EQ:       next_in1_eq = wmasked & MSK_EQ;
            OFS_A1_SWING:     next_a1_swing = wmasked & MSK_SWING;
            OFS_A1_EMPH:      next_a1_emph = wmasked & MSK_EMPH;
            OFS_IN1_THRESH:   next_in1_thresh =
                                 wmasked & MSK_THRESH;
            default:          next_b0_emph = b0_emph;
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         b0_emph      <= RST_EMPH;
         a1_idle_rate <= RST_IDLE_RATE;
         in1_eq       <= RST_EQ;
         a1_swing     <= RST_SWING;
         a1_emph      <= RST_EMPH;
         in1_thresh   <= RST_THRESH;
      end
      else
      begin
         b0_emph      <= next_b0_emph;
         a1_idle_rate <= next_a1_idle_rate;
         in1_eq       <= next_in1_eq;
         a1_swing     <= next_a1_swing;
         a1_emph      <= next_a1_emph;
         in1_thresh   <= next_in1_thresh;
      end
   end

   // =========================================================
   // Read back
   always_comb
   begin
      next_ack = (reg_rd_i | reg_wr_i) & hit;
      unique case (reg_addr_i)
         OFS_B0_EMPH:      next_rdata = b0_emph;
         OFS_A1_IDLE_RATE: next_rdata = a1_idle_rate;
         OFS_IN1_EQ:       next_rdata = in1_eq;
         OFS_A1_SWING:     next_rdata = a1_swing;
         OFS_A1_EMPH:      next_rdata = a1_emph;
         OFS_IN1_THRESH:   next_rdata = in1_thresh;
         default:          next_rdata = 8'h00;
      endcase
      if (!reg_rd_i)
         next_rdata = rdata;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         rdata <= 8'h00;
         ack   <= 1'b0;
      end
      else
      begin
         rdata <= next_rdata;
         ack   <= next_ack;
      end
   end

   assign reg_rdata_o = rdata;
   assign reg_ack_o   = ack;

   // =========================================================
   // Idle and rate decode
   assign cif.idle_rate      = a1_idle_rate;
   assign cif.idle_seen      = seen[0];
   assign cif.rate_high_seen = seen[1];

   lcr_idle_rate_ctrl u_idle_rate
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .cif        (cif)
   );

   // =========================================================
   // Analog control fields
   assign output_b_lane0_tx_emphasis_type_o  = b0_emph[EMPH_TYPE_BIT];
   assign output_b_lane0_tx_emphasis_level_o = b0_emph[6:0];
   assign output_a_lane1_tx_emphasis_type_o  = a1_emph[EMPH_TYPE_BIT];
   assign output_a_lane1_tx_emphasis_level_o = a1_emph[6:0];
   assign output_a_lane1_mute_o              = cif.mute;
   assign output_a_lane1_signal_detect_en_o  = cif.sd_en;
   assign output_a_lane1_rate_high_o         = cif.rate_high;
   assign output_a_lane1_output_swing_o      = a1_swing[6:0];
   // Reserved swing code is passed on but flagged for the trim logic
   assign output_a_lane1_swing_reserved_o    =
      (a1_swing[6:0] == SWING_RESERVED);
   assign input_lane1_eq_enable_o   = in1_eq[EQ_EN_BIT];
   assign input_lane1_gain_stage_o  = in1_eq[EQ_GAIN_LO +: 2];
   assign input_lane1_boost_level_o = in1_eq[2:0];
   assign input_lane1_thresh_deassert_o =
      lcr_thresh_t'(in1_thresh[THR_DEASSERT_LO +: 2]);
   assign input_lane1_thresh_assert_o   =
      lcr_thresh_t'(in1_thresh[THR_ASSERT_LO +: 2]);

   // =========================================================
   // Checks
   a_b0_emph_write: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == OFS_B0_EMPH |=>
      {output_b_lane0_tx_emphasis_type_o,
       output_b_lane0_tx_emphasis_level_o} == $past(reg_wdata_i))
      else $error("emphasis split wrong");
   a_emph_flat_6db: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == OFS_A1_EMPH && (reg_wdata_i == EMPH_0DB ||
      reg_wdata_i == EMPH_6DB) |=> output_a_lane1_tx_emphasis_type_o ==
      $past(reg_wdata_i[7]) && output_a_lane1_tx_emphasis_level_o ==
      $past(reg_wdata_i[6:0])) else $error("emphasis code lost");
   a_emph_deep_codes: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == OFS_A1_EMPH && reg_wdata_i == EMPH_12DB |=>
      output_a_lane1_tx_emphasis_type_o &&
      output_a_lane1_tx_emphasis_level_o == 7'h20)
      else $error("deep emphasis code lost");
   a_eq_field_split: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == OFS_IN1_EQ |=> {input_lane1_eq_enable_o,
      input_lane1_gain_stage_o, input_lane1_boost_level_o} ==
      $past(reg_wdata_i[5:0])) else $error("equaliser fields wrong");
   a_eq_reset_bypass: assert property (
      @(posedge core_clk_i)
      $past(rst_i) && !rst_i |-> input_lane1_eq_enable_o &&
      input_lane1_gain_stage_o == 2'h0 && input_lane1_boost_level_o == 3'h0)
      else $error("equaliser not bypass after reset");
   a_swing_masked: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == OFS_A1_SWING |=>
      output_a_lane1_output_swing_o == $past(reg_wdata_i[6:0]) &&
      a1_swing[7] == 1'b0) else $error("swing write wrong");
   a_thresh_fields: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == OFS_IN1_THRESH |=>
      input_lane1_thresh_deassert_o == $past(reg_wdata_i[3:2]) &&
      input_lane1_thresh_assert_o == $past(reg_wdata_i[1:0]))
      else $error("threshold fields wrong");
   a_thresh_default: assert property (
      @(posedge core_clk_i)
      $past(rst_i) && !rst_i |-> input_lane1_thresh_deassert_o ==
      LCR_THR_110_70 && input_lane1_thresh_assert_o == LCR_THR_110_70)
      else $error("threshold default wrong");
   a_fields_hold: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      !reg_wr_i |=> $stable({b0_emph, a1_idle_rate, in1_eq, a1_swing,
      a1_emph, in1_thresh})) else $error("field changed unwritten");
   a_read_back: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      reg_rd_i && !reg_wr_i && reg_addr_i == OFS_IN1_EQ |=>
      reg_rdata_o == in1_eq && reg_ack_o) else $error("read back wrong");

   c_emph_9db: cover property (@(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == OFS_B0_EMPH && reg_wdata_i == EMPH_9DB);
   c_eq_max: cover property (@(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == OFS_IN1_EQ && reg_wdata_i == EQ_MAX_BOOST);
   c_swing_1200: cover property (@(posedge core_clk_i) disable iff (rst_i)
      output_a_lane1_output_swing_o == SWING_1200MV);
endmodule : lcr_regs
`default_nettype wire

// File: pkg/lcr_pkg.sv
// Lane conditioning register slice: offsets, resets, masks, field positions.
// Assumes an 8-bit register access port driven by the management engine.
package lcr_pkg;
   // =========================================================
   // Register offsets
   localparam logic [7:0] OFS_B0_EMPH      = 8'h35;
   localparam logic [7:0] OFS_A1_IDLE_RATE = 8'h39;
   localparam logic [7:0] OFS_IN1_EQ       = 8'h3A;
   localparam logic [7:0] OFS_A1_SWING     = 8'h3B;
   localparam logic [7:0] OFS_A1_EMPH      = 8'h3C;
   localparam logic [7:0] OFS_IN1_THRESH   = 8'h3D;
   // =========================================================
   // Reset values
   localparam logic [7:0] RST_EMPH      = 8'h03;
   localparam logic [7:0] RST_IDLE_RATE = 8'h00;
   localparam logic [7:0] RST_EQ        = 8'h20;
   localparam logic [7:0] RST_SWING     = 8'h03;
   localparam logic [7:0] RST_THRESH    = 8'h00;
   // =========================================================
   // Writable bits; reserved bits are dropped and read as zero
   localparam logic [7:0] MSK_EMPH      = 8'hFF;
   localparam logic [7:0] MSK_IDLE_RATE = 8'h33;
   localparam logic [7:0] MSK_EQ        = 8'h3F;
   localparam logic [7:0] MSK_SWING     = 8'h7F;
   localparam logic [7:0] MSK_THRESH    = 8'h0F;
   // =========================================================
   // Field positions
   localparam int EMPH_TYPE_BIT  = 7;
   localparam int IDLE_AUTO_BIT  = 5;
   localparam int IDLE_SEL_BIT   = 4;
   localparam int RATE_AUTO_BIT  = 1;
   localparam int RATE_SEL_BIT   = 0;
   localparam int EQ_EN_BIT      = 5;
   localparam int EQ_GAIN_LO     = 3;
   localparam int THR_DEASSERT_LO = 2;
   localparam int THR_ASSERT_LO  = 0;
   localparam int SYNC_STAGES    = 3;
   // =========================================================
   // Documented codes
   localparam logic [7:0] EMPH_0DB      = 8'h01;
   localparam logic [7:0] EMPH_6DB      = 8'h88;
   localparam logic [7:0] EMPH_9DB      = 8'h90;
   localparam logic [7:0] EMPH_12DB     = 8'hA0;
   localparam logic [7:0] EQ_MAX_BOOST  = 8'h3D;
   localparam logic [6:0] SWING_600MV   = 7'h03;
   localparam logic [6:0] SWING_800MV   = 7'h07;
   localparam logic [6:0] SWING_1000MV  = 7'h0F;
   localparam logic [6:0] SWING_1200MV  = 7'h1F;
   localparam logic [6:0] SWING_RESERVED = 7'h3F;

   typedef enum logic [1:0] {
      LCR_THR_110_70  = 2'b00,
      LCR_THR_150_110 = 2'b01,
      LCR_THR_170_130 = 2'b10,
      LCR_THR_190_150 = 2'b11
   } lcr_thresh_t;
endpackage : lcr_pkg

// File: pkg/lcr_ctrl_if.sv
// Carrier between the register slice and the idle/rate control decoder.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface lcr_ctrl_if;
   logic [7:0] idle_rate;
   logic       idle_seen;
   logic       rate_high_seen;
   logic       mute;
   logic       sd_en;
   logic       rate_high;

   modport regs (output idle_rate, idle_seen, rate_high_seen,
                 input  mute, sd_en, rate_high);
   modport ctrl (input  idle_rate, idle_seen, rate_high_seen,
                 output mute, sd_en, rate_high);
endinterface : lcr_ctrl_if
`default_nettype wire

// File: verilog/lcr_idle_rate_ctrl.sv
// Output idle and rate selection for output_a_lane1.
// Assumes detector inputs are already synchronised to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module lcr_idle_rate_ctrl
   import lcr_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   lcr_ctrl_if.ctrl  cif
);
   logic idle_auto;
   logic idle_sel;
   logic rate_auto;
   logic rate_sel;
   logic mute;
   logic sd_en;
   logic rate_high;
   logic next_mute;
   logic next_sd_en;
   logic next_rate_high;

   assign idle_auto = cif.idle_rate[IDLE_AUTO_BIT];
   assign idle_sel  = cif.idle_rate[IDLE_SEL_BIT];
   assign rate_auto = cif.idle_rate[RATE_AUTO_BIT];
   assign rate_sel  = cif.idle_rate[RATE_SEL_BIT];

   // =========================================================
   // Decode
   always_comb
   begin
      if (idle_auto)
      begin
         next_mute  = cif.idle_seen;
         next_sd_en = 1'b1;
      end
      else
      begin
         next_mute  = idle_sel;
         next_sd_en = 1'b0;
      end
      next_rate_high = rate_auto ? cif.rate_high_seen
                                 : rate_sel;
   end

   // Registered so the analog controls never see decode glitches
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         mute      <= 1'b0;
         sd_en     <= 1'b0;
         rate_high <= 1'b0;
      end
      else
      begin
         mute      <= next_mute;
         sd_en     <= next_sd_en;
         rate_high <= next_rate_high;
      end
   end

   assign cif.mute      = mute;
   assign cif.sd_en     = sd_en;
   assign cif.rate_high = rate_high;

   // =========================================================
   // Checks
   a_idle_auto_follow: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      idle_auto |=> mute == $past(cif.idle_seen) && sd_en)
      else $error("auto idle not followed");
   a_idle_manual_mute: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (!idle_auto && idle_sel) |=> mute)
      else $error("manual mute missing");
   a_idle_manual_on: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (!idle_auto && !idle_sel) |=> !mute && !sd_en)
      else $error("manual on broken");
   a_idle_sel_used: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      !idle_auto |=> mute == $past(idle_sel))
      else $error("idle select ignored");
   a_rate_manual: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      !rate_auto |=> rate_high == $past(rate_sel))
      else $error("manual rate wrong");
   a_rate_auto_follow: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      rate_auto |=> rate_high == $past(cif.rate_high_seen))
      else $error("auto rate wrong");
   c_auto_mute: cover property (@(posedge core_clk_i) disable iff (rst_i)
      idle_auto && mute);
   c_auto_rate_high: cover property (@(posedge core_clk_i)
      disable iff (rst_i) rate_auto && rate_high);
endmodule : lcr_idle_rate_ctrl
`default_nettype wire

// File: sim/lcr_host_model.sv
// Host-side model: byte register accesses and the analog detector levels.
// Assumes the register port contract: one-cycle strobes, ack one edge later.
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model
(
   input  wire logic       core_clk_i,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       reg_ack_i,
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic      [7:0] reg_wdata_o,
   output logic            reg_rd_o,
   output logic            idle_raw_o,
   output logic            rate_raw_o
);
   // =========================================================
   // Access tasks
   initial
   begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o    = 1'b0;
      idle_raw_o  = 1'b0;
      rate_raw_o  = 1'b0;
   end

   // Strobe lasts one cycle; the response is taken one edge after it
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     output logic ack);
      @(posedge core_clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_o    <= 1'b0;
      @(posedge core_clk_i);
      ack = reg_ack_i;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic ack);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_o   <= 1'b0;
      @(posedge core_clk_i);
      d   = reg_rdata_i;
      ack = reg_ack_i;
   endtask : rd

   task automatic set_det(input logic idle, input logic rate);
      @(posedge core_clk_i);
      idle_raw_o <= idle;
      rate_raw_o <= rate;
   endtask : set_det
endmodule : lcr_host_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the lane conditioning register slice.
// Assumes lcr_regs and lcr_host_model compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb
   import lcr_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr, wdata, rdata;
   logic        wr, rd, ack, idle_raw, rate_raw;
   logic        b0_ty, a1_ty, mute, sd_en, rate_hi, sw_rsv, eq_en;
   logic [6:0]  b0_lv, a1_lv, swing;
   logic [1:0]  gain, c;
   logic [2:0]  boost;
   lcr_thresh_t thr_de, thr_as;
   logic [7:0]  d;
   logic        a;
   int          mismatches = 0;
   int          n_compared = 0;
   logic [7:0]  ofs [6] = '{OFS_B0_EMPH, OFS_A1_IDLE_RATE, OFS_IN1_EQ,
                            OFS_A1_SWING, OFS_A1_EMPH, OFS_IN1_THRESH};
   logic [7:0]  rstv [6] = '{RST_EMPH, RST_IDLE_RATE, RST_EQ, RST_SWING,
                             RST_EMPH, RST_THRESH};
   logic [7:0]  em [5] = '{EMPH_0DB, EMPH_6DB, EMPH_9DB, EMPH_12DB, 8'hE8};
   logic [6:0]  sw [5] = '{SWING_600MV, SWING_800MV, SWING_1000MV,
                           SWING_1200MV, SWING_RESERVED};
   // Row: write byte, idle raw, rate raw, then mute, sd_en, rate_high
   logic [12:0] ir [7] = '{{8'h10, 5'b00100}, {8'h00, 5'b11000},
                           {8'h01, 5'b00001}, {8'h30, 5'b00010},
                           {8'h20, 5'b10110}, {8'h02, 5'b01001},
                           {8'h03, 5'b00000}};
   logic [7:0]  bad [3] = '{8'h34, 8'h36, 8'h3E};

   always #4 clk = ~clk;

   lcr_host_model lcr_host_model_inst (
      .core_clk_i(clk), .reg_rdata_i(rdata), .reg_ack_i(ack),
      .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
      .reg_rd_o(rd), .idle_raw_o(idle_raw), .rate_raw_o(rate_raw));

   lcr_regs lcr_regs_inst (
      .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .reg_ack_o(ack), .input_lane1_idle_raw_i(idle_raw),
      .input_lane1_rate_high_raw_i(rate_raw),
      .output_b_lane0_tx_emphasis_type_o(b0_ty),
      .output_b_lane0_tx_emphasis_level_o(b0_lv),
      .output_a_lane1_tx_emphasis_type_o(a1_ty),
      .output_a_lane1_tx_emphasis_level_o(a1_lv),
      .output_a_lane1_mute_o(mute),
      .output_a_lane1_signal_detect_en_o(sd_en),
      .output_a_lane1_rate_high_o(rate_hi),
      .output_a_lane1_output_swing_o(swing),
      .output_a_lane1_swing_reserved_o(sw_rsv),
      .input_lane1_eq_enable_o(eq_en), .input_lane1_gain_stage_o(gain),
      .input_lane1_boost_level_o(boost),
      .input_lane1_thresh_deassert_o(thr_de),
      .input_lane1_thresh_assert_o(thr_as));

   // =========================================================
   // Compare and access helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic wchk(input logic [7:0] ad, input logic [7:0] dt);
      logic k;
      lcr_host_model_inst.wr(ad, dt, k);
      chk({7'h00, k}, 8'h01);
   endtask : wchk

   task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
      logic [7:0] v;
      logic       k;
      lcr_host_model_inst.rd(ad, v, k);
      chk(v, exp);
      chk({7'h00, k}, 8'h01);
   endtask : rchk

   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   // =========================================================
   // Tests
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) rchk(ofs[i], rstv[i]);
      chk({b0_ty, b0_lv}, RST_EMPH);
      chk({2'h0, eq_en, gain, boost}, RST_EQ);
      chk({4'h0, thr_de, thr_as}, 8'h00);
      chk({5'h00, mute, sd_en, rate_hi}, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 5; i++)
      begin
         wchk(OFS_B0_EMPH, em[i]);
         wchk(OFS_A1_EMPH, em[4-i]);
         chk({b0_ty, b0_lv}, em[i]);
         chk({a1_ty, a1_lv}, em[4-i]);
         rchk(OFS_B0_EMPH, em[i]);
      end
      $display("test emphasis done");
      wchk(OFS_IN1_EQ, EQ_MAX_BOOST);
      chk({2'h0, eq_en, gain, boost}, EQ_MAX_BOOST);
      rchk(OFS_IN1_EQ, EQ_MAX_BOOST);
      wchk(OFS_IN1_EQ, 8'h0A);
      chk({2'h0, eq_en, gain, boost}, 8'h0A);
      for (int i = 0; i < 5; i++)
      begin
         wchk(OFS_A1_SWING, {1'b0, sw[i]});
         chk({1'b0, swing}, {1'b0, sw[i]});
         chk({7'h00, sw_rsv}, {7'h00, sw[i] == SWING_RESERVED});
      end
      for (int i = 0; i < 4; i++)
      begin
         c = 2'(i);
         wchk(OFS_IN1_THRESH, {4'h0, c, ~c});
         chk({4'h0, thr_de, thr_as}, {4'h0, c, ~c});
         rchk(OFS_IN1_THRESH, {4'h0, c, ~c});
      end
      $display("test fields done");
      // Detector path needs five edges; six leaves margin
      for (int i = 0; i < 7; i++)
      begin
         lcr_host_model_inst.set_det(ir[i][4], ir[i][3]);
         repeat (6) @(posedge clk);
         wchk(OFS_A1_IDLE_RATE, ir[i][12:5]);
         @(posedge clk);
         #1 chk({5'h00, mute, sd_en, rate_hi}, {5'h00, ir[i][2:0]});
      end
      wchk(OFS_A1_IDLE_RATE, MSK_IDLE_RATE);
      rchk(OFS_A1_IDLE_RATE, MSK_IDLE_RATE);
      $display("test idle rate done");
      for (int i = 0; i < 3; i++)
      begin
         lcr_host_model_inst.wr(bad[i], 8'h5A, a);
         chk({7'h00, a}, 8'h00);
         lcr_host_model_inst.rd(bad[i], d, a);
         chk(d, 8'h00);
         chk({7'h00, a}, 8'h00);
         rchk(OFS_B0_EMPH, em[4]);
      end
      $display("test unmapped done");
      // Mid-run reset must bring every field back to its default
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) rchk(ofs[i], rstv[i]);
      chk({b0_ty, b0_lv}, RST_EMPH);
      chk({2'h0, eq_en, gain, boost}, RST_EQ);
      chk({4'h0, thr_de, thr_as}, 8'h00);
      chk({5'h00, mute, sd_en, rate_hi}, 8'h00);
      $display("test second reset done");
      end_sim;
   end

   initial
   begin
      #200000;
      mismatches++;
      end_sim;
   end
endmodule : tb
`default_nettype wire
